//--- hdl/otss_pkg.sv
// Constants and types for the overtravel stop selector
// Overview of operation
// RULE1 - Direction bit zero means CCW forward
// RULE2 - Forward input OFF gives forward overtravel
// RULE3 - Reverse input OFF gives reverse overtravel
// RULE4 - Forward enable bit one ignores forward input
// RULE5 - Reverse enable bit one ignores reverse input
// RULE6 - No allocation of either input disables overtravel
// RULE7 - Four stop methods for alarms, overtravel, servo OFF
// RULE8 - Zero clamp holds position at reference zero
// RULE9 - Coasting after stop releases motor control
// RULE10 - Do-not-stop treats alarm as warning
// RULE11 - Group-1 selection for class-1, safe, servo OFF
// RULE12 - Overtravel selection maps four stop pairs
// RULE13 - Reverse brake forces speed zero, no ramp
// RULE14 - Group-2 selection maps six stop pairs
// RULE15 - Reverse brake uses torque limit, max 350
// RULE16 - Alarm selection wins over overtravel selection
package otss_pkg;

    // ==========================================================
    // Field widths and defaults
    localparam int unsigned ALLOC_W     = 4;
    localparam int unsigned ALLOC_N     = 8;
    localparam int unsigned TRQ_W       = 9;
    localparam logic [ALLOC_W-1:0] ALLOC_FWD = 4'h1;
    localparam logic [ALLOC_W-1:0] ALLOC_REV = 4'h2;
    localparam logic [TRQ_W-1:0]  TRQ_MAX     = 9'h15e;
    localparam logic [TRQ_W-1:0]  TRQ_DEFAULT = 9'h12c;
    localparam logic [2:0] G1_DEFAULT = 3'h0;
    localparam logic [2:0] OT_DEFAULT = 3'h0;
    localparam logic [2:0] G2_DEFAULT = 3'h0;

    // ==========================================================
    // Enumerations
    typedef enum logic [1:0] {
        STOP_DB,
        STOP_COAST,
        STOP_REV_BRAKE,
        STOP_NONE
    } otss_stop_type;

    typedef enum logic [1:0] {
        HOLD_COAST,
        HOLD_DB,
        HOLD_ZERO_CLAMP,
        HOLD_RUN
    } otss_hold_type;

    typedef enum logic [1:0] {
        CAUSE_NONE,
        CAUSE_GROUP1,
        CAUSE_GROUP2,
        CAUSE_OT
    } otss_cause_type;

endpackage

//--- hdl/otss_cfg_if.sv
// Latched configuration bundle passed from top to decoder
`timescale 1ns/1ns
interface otss_cfg_if;
    logic [2:0] g1_sel;
    logic [2:0] ot_sel;
    logic [2:0] g2_sel;
    modport src (output g1_sel, output ot_sel, output g2_sel);
    modport dst (input g1_sel, input ot_sel, input g2_sel);
endinterface

//--- hdl/otss_decode.sv
// Maps the active cause and latched selections to stop method and hold state
`timescale 1ns/1ns
module otss_decode
    import otss_pkg::*;
(
    otss_cfg_if.dst              cfg,
    input  otss_cause_type       i_cause,
    output otss_stop_type        o_method,
    output otss_hold_type        o_hold
);
    always_comb
    begin
        o_method = STOP_DB;
        o_hold   = HOLD_COAST;
        unique case (i_cause)
            CAUSE_NONE:
            begin
                o_method = STOP_NONE;
                o_hold   = HOLD_RUN;
            end
            CAUSE_GROUP1:
            begin
                // Unlisted codes fall back to the default pair
                case (cfg.g1_sel)                                            // [RULE11]
                    3'h1:    begin o_method = STOP_DB;    o_hold = HOLD_DB;    end
                    3'h2:    begin o_method = STOP_COAST; o_hold = HOLD_COAST; end
                    default: begin o_method = STOP_DB;    o_hold = HOLD_COAST; end
                endcase
            end
            CAUSE_OT:
            begin
                case (cfg.ot_sel)                                            // [RULE12]
                    3'h1:    begin o_method = STOP_COAST;     o_hold = HOLD_COAST;      end
                    3'h2:    begin o_method = STOP_REV_BRAKE; o_hold = HOLD_ZERO_CLAMP; end
                    3'h3:    begin o_method = STOP_REV_BRAKE; o_hold = HOLD_COAST;      end
                    default: begin o_method = STOP_DB;        o_hold = HOLD_COAST;      end
                endcase
            end
            CAUSE_GROUP2:
            begin
                case (cfg.g2_sel)                                            // [RULE14]
                    3'h1:    begin o_method = STOP_DB;        o_hold = HOLD_DB;    end
                    3'h2:    begin o_method = STOP_COAST;     o_hold = HOLD_COAST; end
                    3'h3:    begin o_method = STOP_REV_BRAKE; o_hold = HOLD_DB;    end
                    3'h4:    begin o_method = STOP_REV_BRAKE; o_hold = HOLD_COAST; end
                    3'h5:    begin o_method = STOP_NONE;      o_hold = HOLD_RUN;   end // [RULE10]
                    default: begin o_method = STOP_DB;        o_hold = HOLD_COAST; end
                endcase
            end
        endcase
    end
endmodule

//--- hdl/otss_top.sv
// Overtravel qualification, rotation sense and stop method selection
`timescale 1ns/1ns
module otss_top
    import otss_pkg::*;
(
    input  wire logic                  I_CORE_CLK,
    input  wire logic                  I_ARST_N,
    input  wire logic                  I_RESTART,
    input  wire logic                  I_FWD_DRIVE_PROHIBIT,
    input  wire logic                  I_REV_DRIVE_PROHIBIT,
    input  wire logic                  I_DIR_SELECT,
    input  wire logic                  I_FWD_PROHIBIT_ENABLE,
    input  wire logic                  I_REV_PROHIBIT_ENABLE,
    input  wire logic [ALLOC_N*ALLOC_W-1:0] I_INPUT_ALLOCATION_MAP,
    input  wire logic [2:0]            I_GROUP1_STOP_SELECT,
    input  wire logic [2:0]            I_OVERTRAVEL_STOP_SELECT,
    input  wire logic [2:0]            I_GROUP2_STOP_SELECT,
    input  wire logic [TRQ_W-1:0]      I_REVERSE_BRAKE_TORQUE_LIMIT,
    input  wire logic                  I_CLASS1_ALARM,
    input  wire logic                  I_CLASS2_ALARM,
    input  wire logic                  I_SAFE_STATE,
    input  wire logic                  I_SERVO_ON,
    input  wire logic                  I_REF_FWD,
    input  wire logic                  I_REF_REV,
    output logic                       O_MOTOR_CW,
    output logic                       O_MOTOR_CCW,
    output logic                       O_FWD_OVERTRAVEL,
    output logic                       O_REV_OVERTRAVEL,
    output logic                       O_STOPPING,
    output logic [1:0]                 O_STOP_METHOD,
    output logic [1:0]                 O_HOLD_STATE,
    output logic                       O_DYNAMIC_BRAKE,
    output logic                       O_POWER_ON,
    output logic                       O_ZERO_CLAMP,
    output logic                       O_SPEED_REF_ZERO,
    output logic                       O_SOFTSTART_BYPASS,
    output logic [TRQ_W-1:0]           O_TORQUE_LIMIT,
    output logic                       O_ALARM_AS_WARNING
);
    import otss_pkg::*;

    // ==========================================================
    // State
    typedef struct packed {
        logic [1:0]       fwd_sync;
        logic [1:0]       rev_sync;
        logic             dir;
        logic             fwd_en_ign;
        logic             rev_en_ign;
        logic             ot_alloc;
        logic [2:0]       g1;
        logic [2:0]       ot;
        logic [2:0]       g2;
        logic             fwd_ot;
        logic             rev_ot;
        logic             cw;
        logic             ccw;
        otss_stop_type    method;
        otss_hold_type    hold;
        logic             stopping;
        logic [TRQ_W-1:0] trq;
        logic             warn;
    } otss_state_type;

    // ==========================================================
    // Reset image
    // Limits read as ON for two clocks and allocation as present until the first restart,
    // so an OFF limit input can raise overtravel before the settings are known
    localparam otss_state_type RESET_STATE = '{
        fwd_sync:   2'h3,
        rev_sync:   2'h3,
        dir:        1'b0,
        fwd_en_ign: 1'b0,
        rev_en_ign: 1'b0,
        ot_alloc:   1'b1,
        g1:         G1_DEFAULT,
        ot:         OT_DEFAULT,
        g2:         G2_DEFAULT,
        fwd_ot:     1'b0,
        rev_ot:     1'b0,
        cw:         1'b0,
        ccw:        1'b0,
        method:     STOP_DB,
        hold:       HOLD_COAST,
        stopping:   1'b1,
        trq:        TRQ_DEFAULT,
        warn:       1'b0
    };

    otss_state_type state_ff;
    otss_state_type nxt_state;

    otss_cfg_if     cfg_bus ();
    otss_cause_type cause;
    otss_stop_type  dec_method;
    otss_hold_type  dec_hold;
    logic           alloc_hit;
    logic           g1_evt;
    logic           fwd_blk;
    logic           rev_blk;

    assign cfg_bus.g1_sel = state_ff.g1;
    assign cfg_bus.ot_sel = state_ff.ot;
    assign cfg_bus.g2_sel = state_ff.g2;

    otss_decode u_decode
    (
        .cfg      (cfg_bus),
        .i_cause  (cause),
        .o_method (dec_method),
        .o_hold   (dec_hold)
    );

    // ==========================================================
    // Allocation scan, one slot per entry
    logic [ALLOC_N-1:0] slot_hit;
    genvar gi;
    generate
        for (gi = 0; gi < ALLOC_N; gi++)
        begin : g_slot
            wire logic [ALLOC_W-1:0] code = I_INPUT_ALLOCATION_MAP[gi*ALLOC_W +: ALLOC_W];
            assign slot_hit[gi] = (code == ALLOC_FWD) || (code == ALLOC_REV);
        end
    endgenerate
    assign alloc_hit = |slot_hit;

    // ==========================================================
    // Cause priority: alarms ahead of overtravel
    assign g1_evt = I_CLASS1_ALARM || I_SAFE_STATE || !I_SERVO_ON;

    always_comb
    begin
        fwd_blk = state_ff.fwd_ot && I_REF_FWD;
        rev_blk = state_ff.rev_ot && I_REF_REV;
        if (g1_evt)
            cause = CAUSE_GROUP1;                                            // [RULE11]
        else if (I_CLASS2_ALARM)
            cause = CAUSE_GROUP2;                                            // [RULE16]
        else if (fwd_blk || rev_blk)
            cause = CAUSE_OT;                                                // [RULE7]
        else
            cause = CAUSE_NONE;
    end

    always_comb
    begin
        nxt_state = state_ff;
        nxt_state.fwd_sync = {state_ff.fwd_sync[0], I_FWD_DRIVE_PROHIBIT};
        nxt_state.rev_sync = {state_ff.rev_sync[0], I_REV_DRIVE_PROHIBIT};

        // Settings other than the torque limit only take hold at restart, so a live edit cannot upset a moving axis
        if (I_RESTART)
        begin
            nxt_state.dir        = I_DIR_SELECT;
            nxt_state.fwd_en_ign = I_FWD_PROHIBIT_ENABLE;                   // [RULE4]
            nxt_state.rev_en_ign = I_REV_PROHIBIT_ENABLE;                   // [RULE5]
            nxt_state.ot_alloc   = alloc_hit;                               // [RULE6]
            nxt_state.g1         = I_GROUP1_STOP_SELECT;
            nxt_state.ot         = I_OVERTRAVEL_STOP_SELECT;
            nxt_state.g2         = I_GROUP2_STOP_SELECT;
        end

        nxt_state.fwd_ot = state_ff.ot_alloc && !state_ff.fwd_en_ign
                           && !state_ff.fwd_sync[1];                         // [RULE2] [RULE4] [RULE6]
        nxt_state.rev_ot = state_ff.ot_alloc && !state_ff.rev_en_ign
                           && !state_ff.rev_sync[1];                         // [RULE3] [RULE5] [RULE6]

        nxt_state.method   = dec_method;                                     // [RULE7]
        nxt_state.hold     = dec_hold;
        nxt_state.stopping = (dec_method != STOP_NONE);
        nxt_state.warn     = (cause == CAUSE_GROUP2) && (dec_method == STOP_NONE); // [RULE10]

        // Limit clipped to its top value; the motor's own peak still caps it
        nxt_state.trq = (I_REVERSE_BRAKE_TORQUE_LIMIT > TRQ_MAX) ? TRQ_MAX
                        : I_REVERSE_BRAKE_TORQUE_LIMIT;                      // [RULE15]

        // Forward follows the latched sense; blocked sides drop their drive
        nxt_state.cw  = 1'b0;
        nxt_state.ccw = 1'b0;
        if (dec_method == STOP_NONE)
        begin
            if (I_REF_FWD && !fwd_blk)
            begin
                nxt_state.ccw = !state_ff.dir;                               // [RULE1]
                nxt_state.cw  = state_ff.dir;
            end
            else if (I_REF_REV && !rev_blk)
            begin
                nxt_state.cw  = !state_ff.dir;                               // [RULE1]
                nxt_state.ccw = state_ff.dir;
            end
        end
    end

    always_ff @(posedge I_CORE_CLK or negedge I_ARST_N)
    begin
        if (!I_ARST_N)
        begin
            state_ff <= RESET_STATE;
        end
        else
        begin
            state_ff <= nxt_state;
        end
    end

    // ==========================================================
    // Outputs
    assign O_MOTOR_CW         = state_ff.cw;
    assign O_MOTOR_CCW        = state_ff.ccw;
    assign O_FWD_OVERTRAVEL   = state_ff.fwd_ot;
    assign O_REV_OVERTRAVEL   = state_ff.rev_ot;
    assign O_STOPPING         = state_ff.stopping;
    assign O_STOP_METHOD      = state_ff.method;
    assign O_HOLD_STATE       = state_ff.hold;
    // Brake only closes on a brake stop: a reverse-brake stop keeps the stage powered,
    // so shorting the windings then would fight the drive; the later hold is left to whoever sees rest
    assign O_DYNAMIC_BRAKE    = (state_ff.method == STOP_DB);                // [RULE7]
    assign O_POWER_ON         = (state_ff.method == STOP_REV_BRAKE) || (state_ff.method == STOP_NONE)
                                || (state_ff.hold == HOLD_ZERO_CLAMP);       // [RULE9]
    assign O_ZERO_CLAMP       = (state_ff.hold == HOLD_ZERO_CLAMP);          // [RULE8]
    assign O_SPEED_REF_ZERO   = (state_ff.method == STOP_REV_BRAKE) || O_ZERO_CLAMP; // [RULE13]
    assign O_SOFTSTART_BYPASS = (state_ff.method == STOP_REV_BRAKE);         // [RULE13]
    assign O_TORQUE_LIMIT     = state_ff.trq;                                // [RULE15]
    assign O_ALARM_AS_WARNING = state_ff.warn;
endmodule

//--- tb/otss_sva.sv
// Port-level assertion checker for the overtravel stop selector
`timescale 1ns/1ns
module otss_sva
    import otss_pkg::*;
(
    input  wire logic             I_CORE_CLK,
    input  wire logic             I_ARST_N,
    input  wire logic             I_RESTART,
    input  wire logic             I_FWD_DRIVE_PROHIBIT,
    input  wire logic             I_REV_DRIVE_PROHIBIT,
    input  wire logic             I_CLASS1_ALARM,
    input  wire logic             I_CLASS2_ALARM,
    input  wire logic             I_SAFE_STATE,
    input  wire logic             I_SERVO_ON,
    input  wire logic [2:0]       I_GROUP2_STOP_SELECT,
    input  wire logic [TRQ_W-1:0] I_REVERSE_BRAKE_TORQUE_LIMIT,
    input  wire logic             O_MOTOR_CW,
    input  wire logic             O_MOTOR_CCW,
    input  wire logic             O_FWD_OVERTRAVEL,
    input  wire logic             O_REV_OVERTRAVEL,
    input  wire logic             O_DYNAMIC_BRAKE,
    input  wire logic             O_STOPPING,
    input  wire logic [1:0]       O_STOP_METHOD,
    input  wire logic [1:0]       O_HOLD_STATE,
    input  wire logic             O_POWER_ON,
    input  wire logic             O_ZERO_CLAMP,
    input  wire logic             O_SPEED_REF_ZERO,
    input  wire logic             O_SOFTSTART_BYPASS,
    input  wire logic [TRQ_W-1:0] O_TORQUE_LIMIT,
    input  wire logic             O_ALARM_AS_WARNING
);
    // ==========================================
    // Shadow of the latched group-2 selection
    logic [2:0] g2_sel_ff;
    logic       g1_cause;
    logic       warn_cause;
    always_ff @(posedge I_CORE_CLK or negedge I_ARST_N)
        if (!I_ARST_N) g2_sel_ff <= G2_DEFAULT;
        else if (I_RESTART) g2_sel_ff <= I_GROUP2_STOP_SELECT;
    assign g1_cause   = I_CLASS1_ALARM | I_SAFE_STATE | ~I_SERVO_ON;
    assign warn_cause = I_CLASS2_ALARM & ~g1_cause & (g2_sel_ff == 3'h5);
    default clocking cb @(posedge I_CORE_CLK); endclocking
    default disable iff (!I_ARST_N);
    // ==========================================
    // Properties
    a_stop_flag:
        assert property (O_STOPPING == (O_STOP_METHOD != 2'h3)) else $error("stopping flag off");
    a_warn_runs:
        assert property ($past(I_ARST_N) && $past(warn_cause) |-> O_ALARM_AS_WARNING && O_HOLD_STATE == 2'h3)
        else $error("warning did not keep running");
    a_group1_wins:
        assert property ($past(I_ARST_N) && $past(g1_cause) |-> O_STOP_METHOD != 2'h3 && !O_ALARM_AS_WARNING)
        else $error("group-1 cause did not stop");
    a_rb_ref_zero:
        assert property (O_STOP_METHOD == 2'h2 |-> O_SPEED_REF_ZERO && O_SOFTSTART_BYPASS)
        else $error("reverse brake without zero reference");
    a_rb_torque:
        assert property (O_STOP_METHOD == 2'h2 && $past(I_ARST_N) |-> O_TORQUE_LIMIT ==
            (($past(I_REVERSE_BRAKE_TORQUE_LIMIT) > TRQ_MAX) ? TRQ_MAX : $past(I_REVERSE_BRAKE_TORQUE_LIMIT)))
        else $error("reverse brake torque wrong");
    a_coast_free:
        assert property (O_STOP_METHOD == 2'h1 |-> !O_POWER_ON) else $error("coasting motor powered");
    a_clamp_held:
        assert property (O_ZERO_CLAMP |-> O_HOLD_STATE == 2'h2 && O_POWER_ON) else $error("clamp without loop");
    a_one_sense:
        assert property (!(O_MOTOR_CW && O_MOTOR_CCW)) else $error("both senses driven");
    a_fwd_sync:
        assert property (O_FWD_OVERTRAVEL && $past(I_ARST_N, 3) |-> !$past(I_FWD_DRIVE_PROHIBIT, 3))
        else $error("overtravel without open switch");
    a_rev_sync:
        assert property (O_REV_OVERTRAVEL && $past(I_ARST_N, 3) |-> !$past(I_REV_DRIVE_PROHIBIT, 3))
        else $error("reverse overtravel without open switch");
    a_db_on_brake:
        assert property (O_STOP_METHOD == 2'h0 |-> O_DYNAMIC_BRAKE && !O_POWER_ON)
        else $error("brake stop without dynamic brake");
    a_db_no_drive:
        assert property (O_DYNAMIC_BRAKE |-> !O_POWER_ON && !O_MOTOR_CW && !O_MOTOR_CCW)
        else $error("dynamic brake while driving");
    a_clamp_loop:
        assert property (O_HOLD_STATE == 2'h2 |-> O_ZERO_CLAMP && O_POWER_ON && O_SPEED_REF_ZERO)
        else $error("zero clamp hold without position loop");
endmodule
bind otss_top otss_sva u_otss_sva (
    .I_CORE_CLK, .I_ARST_N, .I_RESTART, .I_FWD_DRIVE_PROHIBIT, .I_CLASS1_ALARM, .I_CLASS2_ALARM,
    .I_REV_DRIVE_PROHIBIT, .O_REV_OVERTRAVEL, .O_DYNAMIC_BRAKE,
    .I_SAFE_STATE, .I_SERVO_ON, .I_GROUP2_STOP_SELECT, .I_REVERSE_BRAKE_TORQUE_LIMIT, .O_MOTOR_CW,
    .O_MOTOR_CCW, .O_FWD_OVERTRAVEL, .O_STOPPING, .O_STOP_METHOD, .O_HOLD_STATE, .O_POWER_ON,
    .O_ZERO_CLAMP, .O_SPEED_REF_ZERO, .O_SOFTSTART_BYPASS, .O_TORQUE_LIMIT, .O_ALARM_AS_WARNING
);

//--- tb/otss_limit_model.sv
// Load axis with forward and reverse limit switches
`timescale 1ns/1ns
module otss_limit_model #(parameter int LIM = 20)
(
    input  wire logic i_clk,
    input  wire logic i_cw_fwd,
    input  wire logic i_cw,
    input  wire logic i_ccw,
    input  wire logic i_power,
    output logic      o_fwd_on,
    output logic      o_rev_on
);
    int pos = 0;
    // Axis only moves while the stage powers the motor; braking is taken as instant
    always @(posedge i_clk)
        if (i_power === 1'b1)
            pos <= pos + ((i_cw_fwd ? i_cw : i_ccw) ? 1 : 0) - ((i_cw_fwd ? i_ccw : i_cw) ? 1 : 0);
    assign o_fwd_on = pos < LIM;
    assign o_rev_on = pos > -LIM;
endmodule

//--- tb/tb_overtravel_stop_selector.sv
// Self-checking bench for the overtravel stop selector
`timescale 1ns/1ns
module tb_overtravel_stop_selector;
    import otss_pkg::*;
    // ==========================================
    // Stimulus, observation and reference table
    logic        clk = 1'b0, arst_n = 1'b0, restart = 1'b0, dir = 1'b0, fen = 1'b0, ren = 1'b0;
    logic        c1 = 1'b0, c2 = 1'b0, safe = 1'b0, son = 1'b0, rf = 1'b0, rr = 1'b0;
    logic [31:0] amap = 32'h0000_0021;
    logic [2:0]  g1 = 3'h0, ot = 3'h0, g2 = 3'h0;
    logic [8:0]  trq = 9'h12c;
    logic [15:0] rnd = 16'h3e54;
    logic        fwd_pin, rev_pin, cw, ccw, fot, rot, pwr, warn;
    logic [1:0]  meth, hold;
    logic [8:0]  tq;
    int          n_mismatch = 0, checked = 0, cycles = 0, i, s;
    // Method times four plus hold, rows group 1, overtravel, group 2; unlisted codes act as 0
    int          tab[3][8] = '{'{0, 1, 4, 0, 0, 0, 0, 0}, '{0, 4, 10, 8, 0, 0, 0, 0}, '{0, 1, 4, 9, 8, 15, 0, 0}};
    otss_top DUT (
        .I_CORE_CLK(clk), .I_ARST_N(arst_n), .I_RESTART(restart), .I_FWD_DRIVE_PROHIBIT(fwd_pin),
        .I_REV_DRIVE_PROHIBIT(rev_pin), .I_DIR_SELECT(dir), .I_FWD_PROHIBIT_ENABLE(fen),
        .I_REV_PROHIBIT_ENABLE(ren), .I_INPUT_ALLOCATION_MAP(amap), .I_GROUP1_STOP_SELECT(g1),
        .I_OVERTRAVEL_STOP_SELECT(ot), .I_GROUP2_STOP_SELECT(g2), .I_REVERSE_BRAKE_TORQUE_LIMIT(trq),
        .I_CLASS1_ALARM(c1), .I_CLASS2_ALARM(c2), .I_SAFE_STATE(safe), .I_SERVO_ON(son), .I_REF_FWD(rf),
        .I_REF_REV(rr), .O_MOTOR_CW(cw), .O_MOTOR_CCW(ccw), .O_FWD_OVERTRAVEL(fot), .O_REV_OVERTRAVEL(rot),
        .O_STOPPING(), .O_STOP_METHOD(meth), .O_HOLD_STATE(hold), .O_DYNAMIC_BRAKE(), .O_POWER_ON(pwr),
        .O_ZERO_CLAMP(), .O_SPEED_REF_ZERO(), .O_SOFTSTART_BYPASS(), .O_TORQUE_LIMIT(tq),
        .O_ALARM_AS_WARNING(warn));
    otss_limit_model PARTNER (.i_clk(clk), .i_cw_fwd(dir), .i_cw(cw), .i_ccw(ccw), .i_power(pwr),
        .o_fwd_on(fwd_pin), .o_rev_on(rev_pin));
    initial forever #2 clk = ~clk;
    // ==========================================
    // Helpers
    function automatic logic [15:0] lfsr(input logic [15:0] v);
        return {v[14:0], v[15] ^ v[13] ^ v[12] ^ v[10]};
    endfunction
    task automatic check(input logic [8:0] seen, input logic [8:0] want);
        checked++;
        if (seen !== want)
        begin
            n_mismatch++;
            $display("unexpected at %0t: got %h want %h", $time, seen, want);
        end
    endtask
    task automatic chk_mh(input int grp, input int sel);
        check({5'h0, meth, hold}, 9'(tab[grp][sel]));
    endtask
    // Settings only count when latched, so this task applies them with a restart pulse
    task automatic restart_with(input int a, input int b, input int c);
        {g1, ot, g2} = {a[2:0], b[2:0], c[2:0]};
        restart = 1'b1;
        @(negedge clk);
        restart = 1'b0;
        @(negedge clk);
    endtask
    task finish_test;
        $display("mismatches %0d comparisons %0d", n_mismatch, checked);
        if (n_mismatch == 0 && checked > 0)
            $display("Testbench passed");
        else
            $display("Testbench failed");
        $finish;
    endtask
    always @(posedge clk)
    begin
        cycles++;
        if (cycles == 5000)
        begin
            n_mismatch++;
            finish_test;
        end
    end
    // ==========================================
    // Scenarios
    initial
    begin
        repeat (3) @(negedge clk);
        chk_mh(0, 0);
        check(tq, 9'h12c);
        arst_n = 1'b1;
        for (s = 0; s < 3; s++)
        begin
            restart_with(s, 0, 0);
            {son, c1, safe} = {s != 0, s == 1, s == 2};
            @(negedge clk);
            chk_mh(0, s);
            {son, c1, safe} = 3'b100;
        end
        for (s = 0; s < 8; s++)
        begin
            rnd = lfsr(rnd);
            trq = rnd[8:0];
            restart_with(0, 0, s);
            c2 = 1'b1;
            @(negedge clk);
            chk_mh(2, s);
            check(warn, s == 5);
            if (s == 3 || s == 4) check(tq, (trq > 9'h15e) ? 9'h15e : trq);
        end
        restart_with(2, 0, 5);
        c1 = 1'b1;
        @(negedge clk);
        chk_mh(0, 2);
        {g2, c1} = 4'h0;
        @(negedge clk);
        chk_mh(2, 5);
        c2 = 1'b0;
        for (s = 0; s < 4; s++)
        begin
            dir = s[0];
            restart_with(0, s, 0);
            rf = 1'b1;
            @(negedge clk);
            check({cw, ccw}, {dir, ~dir});
            for (i = 0; i < 200 && fot !== 1'b1; i++) @(negedge clk);
            @(negedge clk);
            chk_mh(1, s);
            {rf, rr} = 2'b01;
            @(negedge clk);
            check({cw, ccw, meth}, {~dir, dir, 2'h3});
            for (i = 0; i < 200 && rot !== 1'b1; i++) @(negedge clk);
            @(negedge clk);
            chk_mh(1, s);
            rr = 1'b0;
        end
        {fen, ren, rf} = 3'b111;
        restart_with(0, 0, 0);
        repeat (100) @(negedge clk);
        check({fot, rot, meth}, 4'h3);
        {fen, ren, amap} = {2'b00, 32'h3333_3333};
        restart_with(0, 0, 0);
        repeat (5) @(negedge clk);
        check({fot, meth}, 3'h3);
        amap = 32'h0000_0021;
        restart_with(0, 0, 0);
        for (i = 0; i < 20 && fot !== 1'b1; i++) @(negedge clk);
        @(negedge clk);
        check({fot, meth}, 3'h4);
        finish_test;
    end
endmodule
